/* File: verilog/lin_sync_pkg.sv */
// Operation
// R1 - Test route set: test transmit pin drives transceiver, transceiver receive drives test pin.
// R2 - Software configures both test pin functions before enabling the test route.
// R3 - Test route clear: the UART drives the transceiver directly.
// R4 - LIN mode, gating set: UART receive held high until break and sync seen; with the test route set the code passes it ungated.
// R5 - LIN mode, gating clear: receive line passes to the UART ungated.
// R6 - Bit-serial mode, bit 8 set: each bus rising edge raises break flag and interrupt.
// R7 - Bit-serial mode: break timer starts on falling edge, stops on next rising edge.
// R8 - Break timer count equal to written compare value raises an interrupt.
// R9 - Break timer overflow raises an interrupt for fault detection.
// R10 - Mode bit 6 set selects bit-serial bus mode, clear selects LIN mode.
package lin_sync_pkg;

	localparam int ADDR_WIDTH = 8;
	localparam int DATA_WIDTH = 32;
	localparam int STRB_WIDTH = DATA_WIDTH / 8;

	localparam logic [ADDR_WIDTH-1:0] OFFS_CTRL = 8'h00;
	localparam logic [ADDR_WIDTH-1:0] OFFS_STATUS = 8'h04;
	localparam logic [ADDR_WIDTH-1:0] OFFS_TIMER = 8'h08;

	localparam int CTRL_MODE_BIT = 6;
	localparam int CTRL_GATE_BIT = 8;
	localparam int CTRL_TEST_BIT = 9;
	localparam int CTRL_OVF_OFF_BIT = 10;
	localparam int CTRL_CMP_OFF_BIT = 11;

	localparam int STAT_EDGE_BIT = 0;
	localparam int STAT_OVF_BIT = 2;
	localparam int STAT_CMP_BIT = 3;

	localparam logic [DATA_WIDTH-1:0] WORD_ZERO = 32'h0000_0000;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	localparam int TIMER_WIDTH_DEF = 16;
	localparam int TICK_DIV_DEF = 1;

	typedef struct packed {
		logic cmpIrqOff;
		logic ovfIrqOff;
		logic testRoute;
		logic gateEn;
		logic bitSerial;
	} ctrl_t;

	typedef struct packed {
		logic cmpHit;
		logic overflow;
		logic edgeSeen;
	} status_t;

	typedef enum logic [1:0] {
		GATE_WAIT_BREAK,
		GATE_WAIT_SYNC,
		GATE_OPEN
	} gate_state_t;

	localparam ctrl_t CTRL_RESET = '{default: 1'b0};
	localparam status_t STATUS_RESET = '{default: 1'b0};

endpackage

/* File: verilog/bus_edge_detect.sv */
`timescale 1ns/1ps
`default_nettype none
module bus_edge_detect (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic line,
	output logic rise,
	output logic fall
);
	logic prev_q;
	logic prev_d;

	always_comb begin
		prev_d = line;
		rise = line & ~prev_q;
		fall = ~line & prev_q;
	end

	// The idle bus is recessive high, so reset to high avoids a false rising edge.
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			prev_q <= 1'b1;
		end else begin
			prev_q <= prev_d;
		end
	end
endmodule
`default_nettype wire

/* File: verilog/break_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module break_timer import lin_sync_pkg::*; #(
	parameter int TIMER_W = TIMER_WIDTH_DEF,
	parameter int TICK_DIV = TICK_DIV_DEF
) (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic enable,
	input wire logic start,
	input wire logic stop,
	input wire logic [TIMER_W-1:0] compareVal,
	output logic [TIMER_W-1:0] count,
	output logic compareHit,
	output logic overflow
);
	localparam int DIV_W = (TICK_DIV > 1) ? $clog2(TICK_DIV) : 1;
	localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_DIV - 1);
	localparam logic [TIMER_W-1:0] COUNT_MAX = '1;

	logic [DIV_W-1:0] div_q, div_d;
	logic [TIMER_W-1:0] count_q, count_d;
	logic running_q, running_d;
	logic hit_q, hit_d;
	logic ovf_q, ovf_d;
	logic tick;

	always_comb begin
		tick = (div_q == DIV_LAST);
		div_d = tick ? '0 : div_q + 1'b1;
		count_d = count_q;
		running_d = running_q;
		hit_d = 1'b0;
		ovf_d = 1'b0;
		if (!enable) begin
			running_d = 1'b0;
		end else if (stop) begin
			running_d = 1'b0; // R7
		end else if (start) begin
			running_d = 1'b1; // R7
			count_d = '0;
			div_d = '0;
		end else if (running_q && tick) begin
			if (count_q == COUNT_MAX) begin
				ovf_d = 1'b1; // R9
				running_d = 1'b0;
			end else begin
				count_d = count_q + 1'b1;
				hit_d = (count_d == compareVal); // R8
			end
		end
	end

	// The count holds after a stop so software can read the last pulse width.
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			div_q <= '0;
			count_q <= '0;
			running_q <= 1'b0;
			hit_q <= 1'b0;
			ovf_q <= 1'b0;
		end else begin
			div_q <= div_d;
			count_q <= count_d;
			running_q <= running_d;
			hit_q <= hit_d;
			ovf_q <= ovf_d;
		end
	end

	assign count = count_q;
	assign compareHit = hit_q;
	assign overflow = ovf_q;
endmodule
`default_nettype wire

/* File: verilog/lin_rx_gate_break_timer.sv */
// Added by the designer: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module lin_rx_gate_break_timer import lin_sync_pkg::*; #(
	parameter int TIMER_W = TIMER_WIDTH_DEF,
	parameter int TICK_DIV = TICK_DIV_DEF
) (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [DATA_WIDTH-1:0] s_axi_wdata,
	input wire logic [STRB_WIDTH-1:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [DATA_WIDTH-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic uartTxd,
	output logic uartRxd,
	input wire logic testTxPin,
	output logic testRxPin,
	output logic linTxd,
	input wire logic linRxd,
	input wire logic breakFieldSeen,
	input wire logic syncByteSeen,
	output logic breakIrq
);
	logic awHeld_q, awHeld_d;
	logic [ADDR_WIDTH-1:0] awAddr_q, awAddr_d;
	logic wHeld_q, wHeld_d;
	logic [DATA_WIDTH-1:0] wData_q, wData_d;
	logic [STRB_WIDTH-1:0] wStrb_q, wStrb_d;
	logic bValid_q, bValid_d;
	logic [1:0] bResp_q, bResp_d;
	logic rValid_q, rValid_d;
	logic [DATA_WIDTH-1:0] rData_q, rData_d;
	logic [1:0] rResp_q, rResp_d;
	ctrl_t ctrl_q, ctrl_d;
	status_t status_q, status_d;
	logic [TIMER_W-1:0] compare_q, compare_d;
	gate_state_t gate_q, gate_d;
	logic linTxd_q, linTxd_d;
	logic testRx_q, testRx_d;
	logic uartRx_q, uartRx_d;
	logic irq_q, irq_d;

	logic busRise, busFall;
	logic timerHit, timerOvf;
	logic [TIMER_W-1:0] timerCount;
	logic doWrite;
	logic gating;
	logic [DATA_WIDTH-1:0] merged;
	status_t statusClr, statusSet;

	function automatic logic [DATA_WIDTH-1:0] ctrlWord(input ctrl_t c);
		logic [DATA_WIDTH-1:0] w;
		w = WORD_ZERO;
		w[CTRL_MODE_BIT] = c.bitSerial;
		w[CTRL_GATE_BIT] = c.gateEn;
		w[CTRL_TEST_BIT] = c.testRoute;
		w[CTRL_OVF_OFF_BIT] = c.ovfIrqOff;
		w[CTRL_CMP_OFF_BIT] = c.cmpIrqOff;
		return w;
	endfunction

	function automatic ctrl_t wordCtrl(input logic [DATA_WIDTH-1:0] w);
		ctrl_t c;
		c.bitSerial = w[CTRL_MODE_BIT];
		c.gateEn = w[CTRL_GATE_BIT];
		c.testRoute = w[CTRL_TEST_BIT];
		c.ovfIrqOff = w[CTRL_OVF_OFF_BIT];
		c.cmpIrqOff = w[CTRL_CMP_OFF_BIT];
		return c;
	endfunction

	function automatic logic [DATA_WIDTH-1:0] statusWord(input status_t s);
		logic [DATA_WIDTH-1:0] w;
		w = WORD_ZERO;
		w[STAT_EDGE_BIT] = s.edgeSeen;
		w[STAT_OVF_BIT] = s.overflow;
		w[STAT_CMP_BIT] = s.cmpHit;
		return w;
	endfunction

	function automatic logic [DATA_WIDTH-1:0] mergeLanes(input logic [DATA_WIDTH-1:0] old,
		input logic [DATA_WIDTH-1:0] nw, input logic [STRB_WIDTH-1:0] strb);
		logic [DATA_WIDTH-1:0] w;
		w = old;
		for (int i = 0; i < STRB_WIDTH; i++) begin
			if (strb[i]) begin
				w[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return w;
	endfunction

	bus_edge_detect u_edge (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.line(linRxd),
		.rise(busRise),
		.fall(busFall)
	);

	break_timer #(
		.TIMER_W(TIMER_W),
		.TICK_DIV(TICK_DIV)
	) u_timer (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.enable(ctrl_q.bitSerial),
		.start(busFall),
		.stop(busRise),
		.compareVal(compare_q),
		.count(timerCount),
		.compareHit(timerHit),
		.overflow(timerOvf)
	);

	assign s_axi_awready = ~awHeld_q;
	assign s_axi_wready = ~wHeld_q;
	assign s_axi_arready = ~rValid_q;
	assign doWrite = awHeld_q & wHeld_q & ~bValid_q;

	always_comb begin
		awHeld_d = awHeld_q;
		awAddr_d = awAddr_q;
		wHeld_d = wHeld_q;
		wData_d = wData_q;
		wStrb_d = wStrb_q;
		bValid_d = bValid_q;
		bResp_d = bResp_q;
		rValid_d = rValid_q;
		rData_d = rData_q;
		rResp_d = rResp_q;
		ctrl_d = ctrl_q;
		compare_d = compare_q;
		statusClr = STATUS_RESET;
		merged = WORD_ZERO;
		if (s_axi_awvalid && s_axi_awready) begin
			awHeld_d = 1'b1;
			awAddr_d = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			wHeld_d = 1'b1;
			wData_d = s_axi_wdata;
			wStrb_d = s_axi_wstrb;
		end
		if (bValid_q && s_axi_bready) begin
			bValid_d = 1'b0;
		end
		if (doWrite) begin
			awHeld_d = 1'b0;
			wHeld_d = 1'b0;
			bValid_d = 1'b1;
			bResp_d = RESP_OKAY;
			if (awAddr_q == OFFS_CTRL) begin
				merged = mergeLanes(ctrlWord(ctrl_q), wData_q, wStrb_q);
				ctrl_d = wordCtrl(merged); // R10
			end else if (awAddr_q == OFFS_STATUS) begin
				merged = mergeLanes(WORD_ZERO, wData_q, wStrb_q);
				statusClr.edgeSeen = merged[STAT_EDGE_BIT];
				statusClr.overflow = merged[STAT_OVF_BIT];
				statusClr.cmpHit = merged[STAT_CMP_BIT];
			end else if (awAddr_q == OFFS_TIMER) begin
				merged = mergeLanes({{(DATA_WIDTH-TIMER_W){1'b0}}, compare_q}, wData_q, wStrb_q);
				compare_d = merged[TIMER_W-1:0]; // R8
			end else begin
				bResp_d = RESP_SLVERR;
			end
		end
		if (rValid_q && s_axi_rready) begin
			rValid_d = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			rValid_d = 1'b1;
			rResp_d = RESP_OKAY;
			if (s_axi_araddr == OFFS_CTRL) begin
				rData_d = ctrlWord(ctrl_q);
			end else if (s_axi_araddr == OFFS_STATUS) begin
				rData_d = statusWord(status_q);
			end else if (s_axi_araddr == OFFS_TIMER) begin
				rData_d = {{(DATA_WIDTH-TIMER_W){1'b0}}, timerCount}; // R7
			end else begin
				rData_d = WORD_ZERO;
				rResp_d = RESP_SLVERR;
			end
		end
	end

	// A flag set in the same cycle as its clear survives, so no event is lost.
	always_comb begin
		statusSet.edgeSeen = ctrl_q.bitSerial & ctrl_q.gateEn & busRise; // R6
		statusSet.overflow = timerOvf; // R9
		statusSet.cmpHit = timerHit; // R8
		status_d.edgeSeen = (status_q.edgeSeen & ~statusClr.edgeSeen) | statusSet.edgeSeen;
		status_d.overflow = (status_q.overflow & ~statusClr.overflow) | statusSet.overflow;
		status_d.cmpHit = (status_q.cmpHit & ~statusClr.cmpHit) | statusSet.cmpHit;
		irq_d = (status_d.edgeSeen & ctrl_q.gateEn & ctrl_q.bitSerial) // R6
			| (status_d.overflow & ~ctrl_q.ovfIrqOff) // R9
			| (status_d.cmpHit & ~ctrl_q.cmpIrqOff); // R8
	end

	// The gate re-arms whenever gating is switched off, so each frame needs a fresh enable.
	always_comb begin
		gating = ~ctrl_q.bitSerial & ctrl_q.gateEn & ~ctrl_q.testRoute;
		gate_d = gate_q;
		if (!gating) begin
			gate_d = GATE_WAIT_BREAK;
		end else begin
			case (gate_q)
				GATE_WAIT_BREAK: begin
					if (breakFieldSeen) begin
						gate_d = GATE_WAIT_SYNC;
					end
				end
				GATE_WAIT_SYNC: begin
					if (syncByteSeen) begin
						gate_d = GATE_OPEN; // R4
					end
				end
				default: begin
					gate_d = GATE_OPEN;
				end
			endcase
		end
		uartRx_d = (gating && gate_q != GATE_OPEN) ? 1'b1 : linRxd; // R4 R5
		linTxd_d = ctrl_q.testRoute ? testTxPin : uartTxd; // R1 R3
		testRx_d = ctrl_q.testRoute ? linRxd : 1'b1; // R1
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			awHeld_q <= 1'b0;
			awAddr_q <= '0;
			wHeld_q <= 1'b0;
			wData_q <= WORD_ZERO;
			wStrb_q <= '0;
			bValid_q <= 1'b0;
			bResp_q <= RESP_OKAY;
			rValid_q <= 1'b0;
			rData_q <= WORD_ZERO;
			rResp_q <= RESP_OKAY;
			ctrl_q <= CTRL_RESET;
			status_q <= STATUS_RESET;
			compare_q <= '0;
			gate_q <= GATE_WAIT_BREAK;
			linTxd_q <= 1'b1;
			testRx_q <= 1'b1;
			uartRx_q <= 1'b1;
			irq_q <= 1'b0;
		end else begin
			awHeld_q <= awHeld_d;
			awAddr_q <= awAddr_d;
			wHeld_q <= wHeld_d;
			wData_q <= wData_d;
			wStrb_q <= wStrb_d;
			bValid_q <= bValid_d;
			bResp_q <= bResp_d;
			rValid_q <= rValid_d;
			rData_q <= rData_d;
			rResp_q <= rResp_d;
			ctrl_q <= ctrl_d;
			status_q <= status_d;
			compare_q <= compare_d;
			gate_q <= gate_d;
			linTxd_q <= linTxd_d;
			testRx_q <= testRx_d;
			uartRx_q <= uartRx_d;
			irq_q <= irq_d;
		end
	end

	assign s_axi_bvalid = bValid_q;
	assign s_axi_bresp = bResp_q;
	assign s_axi_rvalid = rValid_q;
	assign s_axi_rdata = rData_q;
	assign s_axi_rresp = rResp_q;
	assign linTxd = linTxd_q;
	assign testRxPin = testRx_q;
	assign uartRxd = uartRx_q;
	assign breakIrq = irq_q;
endmodule
`default_nettype wire

/* File: sim/lin_rx_gate_break_timer_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module lin_rx_gate_break_timer_chk import lin_sync_pkg::*; #(
	parameter int TIMER_W = TIMER_WIDTH_DEF,
	parameter int TICK_DIV = TICK_DIV_DEF
) (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [DATA_WIDTH-1:0] s_axi_wdata,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic uartTxd,
	input wire logic uartRxd,
	input wire logic testTxPin,
	input wire logic testRxPin,
	input wire logic linTxd,
	input wire logic linRxd,
	input wire logic syncByteSeen,
	input wire logic breakIrq
);
	logic [ADDR_WIDTH-1:0] awQ;
	logic [2:0] wdQ, sh;
	logic bvPrev, sawSync, gAct;
	// Shadow control {route, gate, mode} updates when bvalid rises, one edge after the register.
	assign gAct = sh[1] & ~sh[0] & ~sh[2];
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			awQ <= '0;
			wdQ <= '0;
			sh <= '0;
			bvPrev <= 1'h0;
			sawSync <= 1'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) awQ <= s_axi_awaddr;
			if (s_axi_wvalid && s_axi_wready) begin
				wdQ <= {s_axi_wdata[CTRL_TEST_BIT], s_axi_wdata[CTRL_GATE_BIT], s_axi_wdata[CTRL_MODE_BIT]};
			end
			bvPrev <= s_axi_bvalid;
			if (s_axi_bvalid && !bvPrev && awQ == OFFS_CTRL && s_axi_bresp == RESP_OKAY) sh <= wdQ;
			sawSync <= gAct & (sawSync | syncByteSeen);
		end
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	sequence wBoth;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	chk_tx_route: assert property ($past(reset_n) && sh[2] == $past(sh[2]) |->
		linTxd == (sh[2] ? $past(testTxPin) : $past(uartTxd))) else $error("tx route wrong");
	chk_test_rx: assert property ($past(reset_n) && sh[2] == $past(sh[2]) |->
		testRxPin == (sh[2] ? $past(linRxd) : 1'h1)) else $error("test rx pin wrong");
	chk_rx_ungated: assert property ($past(reset_n) && sh == $past(sh) && !gAct |->
		uartRxd == $past(linRxd)) else $error("uart rx not following line");
	chk_gate_hold: assert property (gAct && $past(gAct) && !sawSync |-> uartRxd) else $error("gate opened early");
	chk_edge_irq: assert property ($rose(linRxd) && sh[0] && sh[1] |-> ##[1:3] breakIrq) else $error("no edge irq");
	chk_write_answer: assert property (wBoth |-> ##2 s_axi_bvalid) else $error("write answer late");
	chk_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped");
	chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
endmodule
bind lin_rx_gate_break_timer lin_rx_gate_break_timer_chk #(.TIMER_W(TIMER_W), .TICK_DIV(TICK_DIV)) chk_i (.*);
`default_nettype wire

/* File: sim/lin_transceiver_model.sv */
`timescale 1ns/1ps
`default_nettype none
module lin_transceiver_model (
	input wire logic txd,
	input wire logic nodeLow,
	output logic rxd
);
	// Wired-AND bus with a pull-up: a released bus reads high, never the last value.
	assign rxd = txd & ~nodeLow;
endmodule
`default_nettype wire

/* File: sim/lin_rx_gate_break_timer_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module lin_rx_gate_break_timer_tb_top import lin_sync_pkg::*; ;
	localparam int TW = 4;
	logic clk_sys = 1'h0, reset_n = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, uartTxd = 1'h1, testTxPin = 1'h1, nodeLow = 1'h0;
	logic breakFieldSeen = 1'h0, syncByteSeen = 1'h0;
	logic [ADDR_WIDTH-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [DATA_WIDTH-1:0] s_axi_wdata = '0, s_axi_rdata, got;
	logic [STRB_WIDTH-1:0] s_axi_wstrb = 4'hF;
	logic [1:0] s_axi_bresp, s_axi_rresp, resp;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic uartRxd, testRxPin, linTxd, linRxd, breakIrq;
	int num_errors = 0, compares = 0, cyc = 0;
	initial begin
		forever #12.5 clk_sys = ~clk_sys;
	end
	// The small timer width keeps the overflow case to about 16 cycles.
	lin_rx_gate_break_timer #(.TIMER_W(TW)) lin_rx_gate_break_timer_i (.*);
	lin_transceiver_model lin_transceiver_model_i (.txd(linTxd), .nodeLow(nodeLow), .rxd(linRxd));
	task automatic conclude();
		$display("compares=%0d errors=%0d", compares, num_errors);
		if (num_errors == 0 && compares > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 5000) begin
			num_errors++;
			conclude();
		end
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
		compares++;
		if (g !== e) begin
			num_errors++;
			$display("CHECK FAILED t=%0t %s", $time, m);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		do begin
			@(posedge clk_sys);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
		end while (s_axi_awvalid & ~s_axi_awready | s_axi_wvalid & ~s_axi_wready);
		// A late bready makes the slave hold its answer for a while.
		tick(2);
		s_axi_bready <= 1'h1;
		do @(posedge clk_sys); while (s_axi_bvalid !== 1'h1);
		resp = s_axi_bresp;
		s_axi_bready <= 1'h0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk_sys);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do @(posedge clk_sys); while (s_axi_arready !== 1'h1);
		s_axi_arvalid <= 1'h0;
		do @(posedge clk_sys); while (s_axi_rvalid !== 1'h1);
		got = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'h0;
	endtask
	task automatic pulse(input int n);
		@(posedge clk_sys);
		nodeLow <= 1'h1;
		tick(n);
		nodeLow <= 1'h0;
		tick(6);
	endtask
	task automatic status(input logic [31:0] e, input string m);
		rd(OFFS_STATUS);
		chk(got, e, m);
		chk(resp, RESP_OKAY, "status read resp");
		wr(OFFS_STATUS, 32'h0000_000F);
	endtask
	initial begin
		tick(20);
		reset_n <= 1'h1;
		wr(OFFS_CTRL, 32'hFFFF_FFFF);
		chk(resp, RESP_OKAY, "ctrl write resp");
		rd(OFFS_CTRL);
		chk(got, 32'h0000_0F40, "ctrl readback");
		rd(8'h0C);
		chk(resp, RESP_SLVERR, "unmapped read resp");
		chk(got, WORD_ZERO, "unmapped read data");
		wr(8'h10, 32'h0000_0001);
		chk(resp, RESP_SLVERR, "unmapped write resp");
		// Only lane 0 is strobed, so the mode bit clears while the upper control bits keep their value.
		s_axi_wstrb <= 4'h1;
		wr(OFFS_CTRL, 32'hFFFF_FF00);
		s_axi_wstrb <= 4'hF;
		rd(OFFS_CTRL);
		chk(got, 32'h0000_0F00, "byte lane write");
		$display("test registers done");
		wr(OFFS_CTRL, WORD_ZERO);
		uartTxd <= 1'h0;
		tick(3);
		chk(linTxd, 1'h0, "uart drives tx");
		nodeLow <= 1'h1;
		uartTxd <= 1'h1;
		tick(3);
		chk(uartRxd, 1'h0, "rx passes ungated");
		chk(testRxPin, 1'h1, "test rx idle");
		nodeLow <= 1'h0;
		// The test pins already sit at defined levels before the route is switched on.
		wr(OFFS_CTRL, 32'h0000_0200);
		testTxPin <= 1'h0;
		tick(3);
		chk(linTxd, 1'h0, "test pin drives tx");
		testTxPin <= 1'h1;
		uartTxd <= 1'h0;
		nodeLow <= 1'h1;
		tick(3);
		chk(linTxd, 1'h1, "uart cut off");
		chk(testRxPin, 1'h0, "rx to test pin");
		nodeLow <= 1'h0;
		uartTxd <= 1'h1;
		$display("test routing done");
		wr(OFFS_CTRL, 32'h0000_0100);
		nodeLow <= 1'h1;
		tick(3);
		chk(uartRxd, 1'h1, "gated before break");
		breakFieldSeen <= 1'h1;
		tick(1);
		breakFieldSeen <= 1'h0;
		tick(3);
		chk(uartRxd, 1'h1, "gated before sync");
		syncByteSeen <= 1'h1;
		tick(1);
		syncByteSeen <= 1'h0;
		tick(3);
		chk(uartRxd, 1'h0, "open after sync");
		nodeLow <= 1'h0;
		$display("test gating done");
		wr(OFFS_CTRL, 32'h0000_0140);
		pulse(10);
		rd(OFFS_TIMER);
		chk(got >= 9 && got <= 11, 1'h1, "pulse width");
		chk(breakIrq, 1'h1, "edge irq");
		status(32'h0000_0001, "edge flag only");
		chk(breakIrq, 1'h0, "irq cleared");
		wr(OFFS_TIMER, 32'h0000_0005);
		pulse(10);
		status(32'h0000_0009, "compare flag");
		pulse(25);
		status(32'h0000_000D, "overflow flag");
		$display("test bit serial done");
		wr(OFFS_CTRL, 32'h0000_0C40);
		pulse(25);
		chk(breakIrq, 1'h0, "irqs disabled");
		status(32'h0000_000C, "flags without edge");
		wr(OFFS_CTRL, WORD_ZERO);
		pulse(25);
		status(WORD_ZERO, "lin mode no timer");
		$display("test modes done");
		conclude();
	end
endmodule
`default_nettype wire
